// ---- bench/irr_ir_tx.sv ----
/* irr_ir_tx.sv: model of the infrared receiver module on the remote input pin.
 * Assumes a demodulated positive phase output that idles low between frames. */
`timescale 1ns/1ns
module irr_ir_tx (
	// clock
	input wire logic clk_i,
	// remote line
	output logic remote_o
);
	initial remote_o = 1'b0;
	// one high then low symbol, widths in core cycles
	task automatic pulse(input int hi, input int lo);
		remote_o <= 1'b1;
		repeat (hi) @(posedge clk_i);
		remote_o <= 1'b0;
		repeat (lo) @(posedge clk_i);
	endtask : pulse
endmodule : irr_ir_tx

// ---- bench/irr_monitor.sv ----
/* irr_monitor.sv: port checker of the infrared remote receiver, bound at the foot.
 * Assumes an Avalon master that holds each request until waitrequest is low. */
`timescale 1ns/1ns
module irr_monitor
	import irr_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	// avalon-mm slave
	input wire irr_avm_req_t AVM_REQ_I,
	input wire logic [31:0] AVM_READDATA_O,
	input wire logic AVM_WAITREQUEST_O,
	// pins and requests
	input wire logic REMOTE_I,
	input wire logic SUBCLK_I,
	input wire logic IRQ_O,
	input wire logic HOLD_RELEASE_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);
	wire req = AVM_REQ_I.read | AVM_REQ_I.write;

	wreq_one_cycle_a: assert property (!AVM_WAITREQUEST_O |=> AVM_WAITREQUEST_O)
		else $error("waitrequest low for more than one cycle");
	req_answer_a: assert property (req && !$past(req) |=> !AVM_WAITREQUEST_O)
		else $error("request not answered after one wait state");
	idle_wait_a: assert property (!req |-> AVM_WAITREQUEST_O)
		else $error("waitrequest low without a request");
	ack_has_req_a: assert property (!AVM_WAITREQUEST_O |-> req)
		else $error("accept without a pending request");
	rdata_still_a: assert property ($changed(AVM_READDATA_O) |-> $past(AVM_REQ_I.read))
		else $error("read data changed without a read");
	rdata_upper_a: assert property (AVM_READDATA_O[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	irq_sw_clear_a: assert property ($fell(IRQ_O) |-> $past(AVM_REQ_I.write, 2))
		else $error("interrupt request dropped without a write");
	hold_with_irq_a: assert property (HOLD_RELEASE_O |-> IRQ_O || $past(IRQ_O))
		else $error("hold release without interrupt request");
	reset_quiet_a: assert property ($rose(NRST_I) |-> !IRQ_O && AVM_WAITREQUEST_O)
		else $error("outputs not idle after reset");
endmodule : irr_monitor

bind irr_receiver irr_monitor u_mon (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I),
	.AVM_REQ_I(AVM_REQ_I), .AVM_READDATA_O(AVM_READDATA_O),
	.AVM_WAITREQUEST_O(AVM_WAITREQUEST_O), .REMOTE_I(REMOTE_I), .SUBCLK_I(SUBCLK_I),
	.IRQ_O(IRQ_O), .HOLD_RELEASE_O(HOLD_RELEASE_O));

// ---- bench/tb_top.sv ----
/* tb_top.sv: self-checking bench of the infrared remote receiver.
 * Assumes the receiver, its package and the pin model compiled before it. */
`timescale 1ns/1ns
module tb_top;
	import irr_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic subclk = 1'b0;
	irr_avm_req_t req = '0;
	logic [31:0] rdata;
	logic wreq, remote, irq, hold, g;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 32'h2a64;
	logic [7:0] b;
	logic [2:0] p;
	logic [2:0] fm [5] = '{3'h2, 3'h3, 3'h1, 3'h0, 3'h4};
	logic [7:0] pr [5] = '{8'h00, 8'h10, 8'h50, 8'h00, 8'hA0};
	int cyc [5] = '{4, 4, 8, 4, 8};

	always #20 clk = ~clk;
	always #730 subclk = ~subclk;

	irr_receiver DUT (.CORE_CLK_I(clk), .NRST_I(nrst), .AVM_REQ_I(req),
		.AVM_READDATA_O(rdata), .AVM_WAITREQUEST_O(wreq), .REMOTE_I(remote),
		.SUBCLK_I(subclk), .IRQ_O(irq), .HOLD_RELEASE_O(hold));
	irr_ir_tx ir (.clk_i(clk), .remote_o(remote));

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
		n_tests++;
		if (got !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, got);
		end
	endtask : chk

	task automatic bus(input logic w, input int k, input logic [7:0] wd, output logic [7:0] d);
		int n;
		n = 0;
		req.read <= ~w;
		req.write <= w;
		req.address <= 18'h3F89C + 18'(k * 4);
		req.writedata <= {24'h000000, wd};
		req.byteenable <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		d = rdata[7:0];
		if (n >= 50) begin
			n_mismatch++;
			$display("[ERR] bus answer expected 0 seen %b", wreq);
			close_out();
		end
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input int k, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, k, d, x);
	endtask : wr

	task automatic rc(input string nm, input int k, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] x;
		bus(1'b0, k, 8'h00, x);
		chk(nm, {24'h000000, e & m}, {24'h000000, x & m});
	endtask : rc

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			n_mismatch++;
			$display("[ERR] irq expected 1 seen %b", irq);
			close_out();
		end
	endtask : wait_irq

	// partial byte as it sits in the shift register
	function automatic logic [7:0] part(input logic dir, input logic [2:0] q);
		return dir ? {5'h00, q} : {q, 5'h00};
	endfunction : part

	// optional guide, eight bits, three more bits, a closing high
	task automatic send(input logic dir, input int cc, input logic [10:0] s, input logic gd);
		int j;
		if (gd) ir.pulse(6 * cc, 6 * cc);
		for (int i = 0; i < 11; i++) begin
			j = dir ? ((i < 8) ? 7 - i : 18 - i) : i;
			ir.pulse(3 * cc, s[j] ? 7 * cc : 3 * cc);
		end
		ir.pulse(3 * cc, 2);
	endtask : send

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 9; k++) begin
			if (k != 3) rc("reset value", k, 8'h00, (k == 8) ? 8'h40 : 8'hFF);
		end
		rc("unmapped", 9, 8'h00, 8'hFF);
		wr(2, 8'hFF);
		rc("shift read only", 2, 8'h00, 8'hFF);
		for (int k = 5; k < 8; k++) begin
			b = $random(seed);
			wr(k, b);
			rc("width readback", k, b, 8'hFF);
		end
		wr(8, 8'hFF);
		rc("msb readback", 8, 8'hBF, 8'hFF);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			g = (fm[i] == 3'h0 || fm[i] == 3'h1 || fm[i] == 3'h4);
			b = $random(seed);
			p = $random(seed);
			wr(0, {1'b0, fm[i], 4'h7});
			wr(4, pr[i]);
			wr(5, 8'h66);
			wr(6, 8'h33);
			wr(7, 8'h37);
			wr(8, {i[0], 7'h00});
			wr(1, 8'h01);
			wr(0, {1'b1, fm[i], 4'h7});
			send(i[0], cyc[i], {p, b}, g);
			wait_irq();
			rc("byte", 3, b, 8'hFF);
			rc("partial", 2, part(i[0], p), 8'hFF);
			rc("bit count", 4, {pr[i][7:4], 4'h3}, 8'hFF);
			rc("flags", 1, {g, 7'h0B}, 8'hFF);
			chk("hold release", 32'h0, {31'h0, hold});
			wr(1, 8'hAA);
			repeat (2) @(posedge clk);
			chk("masked irq", 32'h0, {31'h0, irq});
			wr(1, 8'h00);
			rc("cleared", 1, 8'h00, 8'hFF);
			wr(0, {1'b0, fm[i], 4'h7});
			rc("stop shift", 2, 8'h00, 8'hFF);
			rc("stop count", 4, pr[i], 8'hFF);
			rc("byte kept", 3, b, 8'hFF);
			$display("test frame %0d done", i);
		end
		wr(8, 8'h00);
		wr(4, 8'h00);
		wr(1, 8'h10);
		wr(0, 8'hA7);
		ir.pulse(28, 20);
		ir.pulse(12, 2);
		wait_irq();
		rc("error flag", 1, 8'h30, 8'hF8);
		rc("error count", 4, 8'h00, 8'hFF);
		rc("error shift", 2, 8'h00, 8'hFF);
		$display("test error done");
		wr(0, 8'h46);
		wr(1, 8'h00);
		wr(1, 8'h10);
		wr(0, 8'hC6);
		ir.pulse(300, 20);
		wait_irq();
		chk("hold release", 32'h1, {31'h0, hold});
		rc("subclock error", 1, 8'h30, 8'hF8);
		$display("test subclock done");
		close_out();
	end
endmodule : tb_top

// ---- rtl/irr_params.svh ----
/*
 * irr_params.svh: offsets, field positions, reset values and counts of the
 * infrared remote receiver. Assumes inclusion by the core.
 */
`ifndef IRR_PARAMS_SVH
`define IRR_PARAMS_SVH

// register indices, byte address is four times the index
`define IRR_IDX_CONTROL 16'hFE27
`define IRR_IDX_IRQ 16'hFE28
`define IRR_IDX_SHIFT 16'hFE29
`define IRR_IDX_BYTE 16'hFE2A
`define IRR_IDX_BITCOUNT 16'hFE2B
`define IRR_IDX_GUIDE_W 16'hFE2C
`define IRR_IDX_ZERO_W 16'hFE2D
`define IRR_IDX_ONE_W 16'hFE2E
`define IRR_IDX_WIDTH_MSB 16'hFE2F

// reset values
`define IRR_RST_BYTE 8'h00
`define IRR_RST_XHW 7'h00

// control register fields
`define IRR_CTL_RUN 7
`define IRR_CTL_DINV 3

// irq register: flag and enable positions
`define IRR_IRQ_GUIDE 7
`define IRR_IRQ_GUIDE_EN 6
`define IRR_IRQ_ERR 5
`define IRR_IRQ_ERR_EN 4
`define IRR_IRQ_FULL 3
`define IRR_IRQ_FULL_EN 2
`define IRR_IRQ_END 1
`define IRR_IRQ_END_EN 0

// width msb register fields
`define IRR_XHW_DIR 7

// reference clock select codes
`define IRR_REF_SUBCLK 3'h6
`define IRR_REF_1TCYC 3'h7

// interrupt vector served by the request output
`define IRR_VECTOR 16'h0013

// measurement counter saturation and match tolerance
`define IRR_MCNT_MAX 5'h1F
`define IRR_TOL 5'h01

`endif

// ---- rtl/irr_pkg.sv ----
/*
 * irr_pkg.sv: types of the infrared remote receiver.
 * Assumes irr_params.svh is on the include path.
 */
package irr_pkg;
	typedef struct packed {
		logic read;
		logic write;
		logic [17:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} irr_avm_req_t;

	typedef enum logic [2:0] {
		FMT_A = 3'h0,
		FMT_B = 3'h1,
		FMT_C = 3'h2,
		FMT_D = 3'h3,
		FMT_E = 3'h4
	} irr_format_t;

	typedef enum logic [5:0] {
		ST_WAIT = 6'h01,
		ST_G_HI = 6'h02,
		ST_G_LO = 6'h04,
		ST_D_HI = 6'h08,
		ST_D_LO = 6'h10,
		ST_DONE = 6'h20
	} irr_state_t;
endpackage : irr_pkg

// ---- rtl/irr_pkg_order_note.sv ----
/*
 * irr_pkg_order_note.sv: empty compilation unit kept out.
 */

// ---- rtl/irr_receiver.sv ----
/*
 * irr_receiver.sv: infrared remote receiver core with an Avalon-MM slave.
 * Assumes one core clock, a remote input pin and a subclock pin that are
 * both asynchronous, and an Avalon master that holds its request stable.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "irr_params.svh"

// Behaviour
// RQ1 - five formats: guide kind, PPM or Manchester, stop bits or not
// RQ2 - pulses timed by reference clock: 1 to 128 cycles or subclock
// RQ3 - each pulse classed 0, 1 or error; only valid bits shift in
// RQ4 - eight valid bits copy to the byte register and set transfer flag
// RQ5 - end flag set when end condition of the format is seen
// RQ6 - four sources share one vector request, each gated by its enable
// RQ7 - started on subclock, a receiver request releases crystal hold
// RQ8 - software starts on subclock before entering crystal hold
// RQ9 - shift fills lsb or msb first from direction bit 7
// RQ10 - shift register stays readable after end for a partial byte
// RQ11 - shift clears on stop, guide ok, first start edge, transfer
// RQ12 - byte register undefined at reset, changes only on transfer
// RQ13 - 3-bit counter counts valid bits, gives partial byte length
// RQ14 - bit counter clears on stop, guide ok or first start edge
// RQ15 - formats C and D ignore guide prescale and guide width
// RQ16 - 5-bit prescaler issues count clock at its selected count
// RQ17 - guide prescale used for guide, data prescale for data pulses
// RQ18 - codes give 4 to 32 in formats A to C, 2 to 16 otherwise
// RQ19 - zero width register defines data 0 width for classing
// RQ20 - one width register defines data 1 width for classing
// RQ21 - new level accepted only after four agreeing reference samples
// RQ22 - select 000 to 101 is 4 to 128 cycles, 110 subclock, 111 one
// RQ23 - hardware sets flags, software clears; request while flag and enable
// RQ24 - run bit starts and stops; settings changed only while stopped
// RQ25 - a new transfer overwrites the byte and sets the flag again
module irr_receiver
	import irr_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	// avalon-mm slave
	input wire irr_avm_req_t AVM_REQ_I,
	output logic [31:0] AVM_READDATA_O,
	output logic AVM_WAITREQUEST_O,
	// pins
	input wire logic REMOTE_I,
	input wire logic SUBCLK_I,
	// requests
	output logic IRQ_O,
	output logic HOLD_RELEASE_O
);

	// reference divider terminal count per select code
	function automatic logic [6:0] ref_term(input logic [2:0] sel);
		case (sel)
			3'h0: ref_term = 7'h03;
			3'h1: ref_term = 7'h07;
			3'h2: ref_term = 7'h0F;
			3'h3: ref_term = 7'h1F;
			3'h4: ref_term = 7'h3F;
			3'h5: ref_term = 7'h7F;
			default: ref_term = 7'h00;
		endcase
	endfunction : ref_term

	// prescaler terminal count per code and format
	function automatic logic [4:0] psc_term(input logic [1:0] code, input logic [2:0] fmt);
		logic half;
		half = (fmt == FMT_D) || (fmt == FMT_E);
		case (code)
			2'h0: psc_term = half ? 5'h01 : 5'h03;
			2'h1: psc_term = half ? 5'h03 : 5'h07;
			2'h2: psc_term = half ? 5'h07 : 5'h0F;
			default: psc_term = half ? 5'h0F : 5'h1F;
		endcase
	endfunction : psc_term

	// measured width within tolerance of a set width
	function automatic logic width_ok(input logic [4:0] meas, input logic [4:0] ref_w);
		width_ok = ({1'b0, meas} + {1'b0, `IRR_TOL} >= {1'b0, ref_w}) &&
			({1'b0, meas} <= {1'b0, ref_w} + {1'b0, `IRR_TOL});
	endfunction : width_ok

	// registers
	logic [7:0] ctrl;
	logic [3:0] flags;
	logic [3:0] enables;
	logic [7:0] rx_shift_reg;
	logic [7:0] rx_byte_reg;
	logic [3:0] prescale;
	logic suspend_resume_flag;
	logic [2:0] bit_counter;
	logic [7:0] guide_width_reg;
	logic [7:0] zero_width_reg;
	logic [7:0] one_width_reg;
	logic [6:0] width_msb_reg;
	logic wreq;

	// receiver state
	irr_state_t state;
	irr_state_t next_state;
	logic rem_s1, rem_s2;
	logic sub_s1, sub_s2, sub_s3;
	logic [6:0] ref_div;
	logic [2:0] hist;
	logic lvl, lvl_d;
	logic [4:0] ir_prescaler;
	logic [4:0] pulse_width_counter;
	logic [4:0] high_w;

	// decoded fields
	wire run_bit = ctrl[`IRR_CTL_RUN];
	wire [2:0] fmt = ctrl[6:4];
	wire dinv = ctrl[`IRR_CTL_DINV];
	wire [2:0] ref_sel = ctrl[2:0];
	wire shift_direction = width_msb_reg[6];
	wire has_guide = (fmt == FMT_A) || (fmt == FMT_B) || (fmt == FMT_E); // [RQ1] [RQ15]
	wire fmt_half = (fmt == FMT_A);
	wire [4:0] gp_hi = {width_msb_reg[1], guide_width_reg[7:4]};
	wire [4:0] gp_lo = {width_msb_reg[0], guide_width_reg[3:0]};
	wire [4:0] d0_hi = {width_msb_reg[3], zero_width_reg[7:4]}; // [RQ19]
	wire [4:0] d0_lo = {width_msb_reg[2], zero_width_reg[3:0]}; // [RQ19]
	wire [4:0] d1_hi = {width_msb_reg[5], one_width_reg[7:4]}; // [RQ20]
	wire [4:0] d1_lo = {width_msb_reg[4], one_width_reg[3:0]}; // [RQ20]

	// reference clock tick
	wire sub_edge = sub_s2 & ~sub_s3;
	wire ref_tick = (ref_sel == `IRR_REF_SUBCLK) ? sub_edge : (ref_div == ref_term(ref_sel)); // [RQ2] [RQ22]

	// noise filter decision
	wire in_pol = rem_s2 ^ dinv;
	wire agree = (hist == {3{in_pol}}); // [RQ21]
	wire rise = lvl & ~lvl_d;
	wire fall = ~lvl & lvl_d;
	wire edge_seen = rise | fall;

	// prescaler and width counter
	wire guide_phase = (state == ST_G_HI) || (state == ST_G_LO);
	wire [1:0] psc_code = guide_phase ? prescale[3:2] : prescale[1:0]; // [RQ17]
	wire cnt_tick = ref_tick && (ir_prescaler == psc_term(psc_code, fmt)); // [RQ16] [RQ18]
	wire sat = (pulse_width_counter == `IRR_MCNT_MAX);

	// bus decode
	wire req = AVM_REQ_I.read | AVM_REQ_I.write;
	wire acc = req & ~wreq;
	wire wr_en = AVM_REQ_I.write & acc & AVM_REQ_I.byteenable[0];
	wire [17:0] adr = AVM_REQ_I.address;
	wire [7:0] wd = AVM_REQ_I.writedata[7:0];
	wire hit_ctrl = (adr == {`IRR_IDX_CONTROL, 2'b00});
	wire hit_irq = (adr == {`IRR_IDX_IRQ, 2'b00});
	wire hit_shift = (adr == {`IRR_IDX_SHIFT, 2'b00});
	wire hit_byte = (adr == {`IRR_IDX_BYTE, 2'b00});
	wire hit_bcnt = (adr == {`IRR_IDX_BITCOUNT, 2'b00});
	wire hit_gpw = (adr == {`IRR_IDX_GUIDE_W, 2'b00});
	wire hit_d0w = (adr == {`IRR_IDX_ZERO_W, 2'b00});
	wire hit_d1w = (adr == {`IRR_IDX_ONE_W, 2'b00});
	wire hit_xhw = (adr == {`IRR_IDX_WIDTH_MSB, 2'b00});
	wire [7:0] irq_view = {flags[3], enables[3], flags[2], enables[2],
		flags[1], enables[1], flags[0], enables[0]};
	wire [7:0] rd_mux =
		hit_ctrl ? ctrl :
		hit_irq ? irq_view :
		hit_shift ? rx_shift_reg :
		hit_byte ? rx_byte_reg :
		hit_bcnt ? {prescale, suspend_resume_flag, bit_counter} :
		hit_gpw ? guide_width_reg :
		hit_d0w ? zero_width_reg :
		hit_d1w ? one_width_reg :
		hit_xhw ? {width_msb_reg[6], 1'b0, width_msb_reg[5:0]} : 8'h00;

	// receive events
	logic ev_gp, ev_err, ev_bit, bit_val, ev_end, clr_rx;
	wire ev_full = ev_bit && (bit_counter == 3'h7); // [RQ4]
	wire [7:0] shifted = shift_direction ? {rx_shift_reg[6:0], bit_val} :
		{bit_val, rx_shift_reg[7:1]}; // [RQ9]
	wire [3:0] set_flags = {ev_gp, ev_err, ev_full, ev_end};
	wire [3:0] keep_flags = (wr_en && hit_irq) ?
		{wd[`IRR_IRQ_GUIDE], wd[`IRR_IRQ_ERR], wd[`IRR_IRQ_FULL], wd[`IRR_IRQ_END]} : 4'hF;
	wire [3:0] next_flags = set_flags | (flags & keep_flags); // [RQ23]
	wire irq_any = |(flags & enables); // [RQ6] [RQ23]
	wire sub_mode = run_bit && (ref_sel == `IRR_REF_SUBCLK);
	wire [3:0] end_state_sel = {3'h0, suspend_resume_flag};

	// sequence of guide, data pulses and end
	always_comb begin
		next_state = state;
		ev_gp = 1'b0;
		ev_err = 1'b0;
		ev_bit = 1'b0;
		bit_val = 1'b0;
		ev_end = 1'b0;
		clr_rx = 1'b0;
		case (state)
			ST_WAIT: begin
				if (lvl) begin
					if (has_guide) begin
						next_state = ST_G_HI;
					end else begin
						next_state = ST_D_HI;
						clr_rx = 1'b1; // [RQ11] [RQ14]
					end
				end
			end
			ST_G_HI: begin
				if (fall) begin
					if (width_ok(pulse_width_counter, gp_hi)) begin
						next_state = ST_G_LO;
					end else begin
						ev_err = 1'b1;
						next_state = ST_WAIT;
					end
				end else if (sat) begin
					ev_err = 1'b1;
					next_state = ST_WAIT;
				end
			end
			ST_G_LO: begin
				if (rise) begin
					if (fmt_half || width_ok(pulse_width_counter, gp_lo)) begin
						ev_gp = 1'b1; // [RQ6]
						clr_rx = 1'b1; // [RQ11] [RQ14]
						next_state = ST_D_HI;
					end else begin
						ev_err = 1'b1;
						next_state = ST_WAIT;
					end
				end else if (sat) begin
					ev_err = 1'b1;
					next_state = ST_WAIT;
				end
			end
			ST_D_HI: begin
				if (fall) begin
					next_state = ST_D_LO;
				end else if (sat) begin
					ev_end = 1'b1; // [RQ5]
					next_state = end_state_sel[0] ? ST_DONE : ST_WAIT;
				end
			end
			ST_D_LO: begin
				if (rise) begin
					if (width_ok(high_w, d0_hi) && width_ok(pulse_width_counter, d0_lo)) begin
						ev_bit = 1'b1; // [RQ3]
						next_state = ST_D_HI;
					end else if (width_ok(high_w, d1_hi) &&
						width_ok(pulse_width_counter, d1_lo)) begin
						ev_bit = 1'b1; // [RQ3]
						bit_val = 1'b1;
						next_state = ST_D_HI;
					end else begin
						ev_err = 1'b1; // [RQ3]
						next_state = ST_WAIT;
					end
				end else if (sat) begin
					ev_end = 1'b1; // [RQ5] [RQ10]
					next_state = end_state_sel[0] ? ST_DONE : ST_WAIT;
				end
			end
			ST_DONE: begin
				if (!suspend_resume_flag) begin
					next_state = ST_WAIT;
				end
			end
			default: begin
				next_state = ST_WAIT;
			end
		endcase
	end

	// pin synchronisers
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rem_s1 <= 1'b0;
			rem_s2 <= 1'b0;
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end else begin
			rem_s1 <= REMOTE_I;
			rem_s2 <= rem_s1;
			sub_s1 <= SUBCLK_I;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end

	// reference divider and noise filter
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ref_div <= 7'h00;
			hist <= 3'h0;
			lvl <= 1'b0;
			lvl_d <= 1'b0;
		end else if (!run_bit) begin
			ref_div <= 7'h00;
			hist <= 3'h0;
			lvl <= 1'b0;
			lvl_d <= 1'b0;
		end else begin
			ref_div <= ref_tick ? 7'h00 : ref_div + 7'h01;
			lvl_d <= lvl;
			if (ref_tick) begin
				hist <= {hist[1:0], in_pol};
				if (agree) begin
					lvl <= in_pol; // [RQ21]
				end
			end
		end
	end

	// prescaler, width counter and state
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ir_prescaler <= 5'h00;
			pulse_width_counter <= 5'h00;
			high_w <= 5'h00;
			state <= ST_WAIT;
		end else if (!run_bit || edge_seen) begin
			ir_prescaler <= 5'h00;
			pulse_width_counter <= 5'h00;
			high_w <= fall ? pulse_width_counter : high_w;
			state <= run_bit ? next_state : ST_WAIT; // [RQ24]
		end else begin
			ir_prescaler <= cnt_tick ? 5'h00 : (ref_tick ? ir_prescaler + 5'h01 : ir_prescaler); // [RQ16]
			pulse_width_counter <= (cnt_tick && !sat) ? pulse_width_counter + 5'h01 :
				pulse_width_counter;
			state <= next_state;
		end
	end

	// shift register and bit counter
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rx_shift_reg <= 8'h00;
			bit_counter <= 3'h0;
		end else if (!run_bit || clr_rx || ev_full) begin
			rx_shift_reg <= 8'h00; // [RQ11]
			bit_counter <= ev_full ? 3'h0 : 3'h0; // [RQ14]
		end else if (ev_bit) begin
			rx_shift_reg <= shifted; // [RQ3] [RQ9]
			bit_counter <= bit_counter + 3'h1; // [RQ13]
		end
	end

	// byte register has no reset value
	always_ff @(posedge CORE_CLK_I) begin
		if (ev_full) begin
			rx_byte_reg <= shifted; // [RQ4] [RQ12] [RQ25]
		end
	end

	// software registers and flags
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl <= 8'h00;
			flags <= 4'h0;
			enables <= 4'h0;
			prescale <= 4'h0;
			suspend_resume_flag <= 1'b0;
			guide_width_reg <= 8'h00;
			zero_width_reg <= 8'h00;
			one_width_reg <= 8'h00;
			width_msb_reg <= `IRR_RST_XHW;
		end else begin
			flags <= next_flags; // [RQ23] [RQ25]
			if (wr_en && hit_ctrl) begin
				ctrl <= wd; // [RQ24]
			end
			if (wr_en && hit_irq) begin
				enables <= {wd[`IRR_IRQ_GUIDE_EN], wd[`IRR_IRQ_ERR_EN],
					wd[`IRR_IRQ_FULL_EN], wd[`IRR_IRQ_END_EN]};
			end
			if (wr_en && hit_bcnt) begin
				prescale <= wd[7:4];
				suspend_resume_flag <= wd[3];
			end
			if (wr_en && hit_gpw) begin
				guide_width_reg <= wd;
			end
			if (wr_en && hit_d0w) begin
				zero_width_reg <= wd;
			end
			if (wr_en && hit_d1w) begin
				one_width_reg <= wd;
			end
			if (wr_en && hit_xhw) begin
				width_msb_reg <= {wd[`IRR_XHW_DIR], wd[5:0]};
			end
		end
	end

	// bus answer and request outputs
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			wreq <= 1'b1;
			AVM_READDATA_O <= 32'h0000_0000;
			IRQ_O <= 1'b0;
			HOLD_RELEASE_O <= 1'b0;
		end else begin
			wreq <= ~(req & wreq);
			if (AVM_REQ_I.read && wreq) begin
				AVM_READDATA_O <= {24'h00_0000, rd_mux};
			end
			IRQ_O <= irq_any; // [RQ6]
			HOLD_RELEASE_O <= sub_mode && irq_any; // [RQ7] [RQ8]
		end
	end

	assign AVM_WAITREQUEST_O = wreq;

endmodule : irr_receiver
